// >>> rtl/hiobj_pkg.sv
// Constants for the handler I/O bin judgment block
// Summary of operation
// - Bin-nine output goes low while the latest binning result is bin nine, else stays high.
// - Out-of-bins output goes low while the binning result matches no defined bin.
// - A panel-load execute level loads the panel whose number is on the panel-select inputs.
// - Measurement-complete goes low only after all judgment outputs hold final values.
// - Conversion-complete falls when conversion ends; the sample may be swapped only after.
// - The error output goes low at level on any sampling, contact, reject, source or limit error.
package hiobj_pkg;
   localparam int unsigned PANEL_W    = 7;
   localparam int unsigned BIN_W      = 4;
   localparam logic [3:0]  BIN_NINE   = 4'h9;
   localparam logic [3:0]  BIN_NONE   = 4'h0;
   localparam logic [3:0]  BIN_MAX    = 4'ha;
   localparam int unsigned CLK_MHZ    = 125;
   localparam int unsigned MEAS_GAP_NS = 16;
   localparam int unsigned MEAS_GAP_CYC =
      ((MEAS_GAP_NS * CLK_MHZ + 999) / 1000) < 1 ? 1 : ((MEAS_GAP_NS * CLK_MHZ + 999) / 1000);
   localparam logic [PANEL_W-1:0] PANEL_RST = 7'h00;

   typedef enum logic [1:0] {
      HIOBJ_IDLE = 2'b00,
      HIOBJ_CONV = 2'b01,
      HIOBJ_HOLD = 2'b11,
      HIOBJ_DONE = 2'b10
   } hiobj_state_e;
endpackage : hiobj_pkg

// >>> rtl/hiobj_top.sv
// Handler I/O judgment outputs, strobes and panel-load inputs
`timescale 1ns/10ps
`default_nettype none
module hiobj_top (
   // Clock and reset
   input  wire logic                         clk_sys,
   input  wire logic                         srst,
   // Measurement core side
   input  wire logic                         meas_start,
   input  wire logic                         conv_done,
   input  wire logic                         judge_valid,
   input  wire logic [hiobj_pkg::BIN_W-1:0]  judge_bin,
   input  wire logic                         err_event,
   // Panel-select pins, active low
   input  wire logic                         panel_sel_b0,
   input  wire logic                         panel_sel_b1,
   input  wire logic                         panel_sel_b2,
   input  wire logic                         panel_sel_b3,
   input  wire logic                         panel_sel_b4,
   input  wire logic                         panel_sel_b5,
   input  wire logic                         panel_sel_b6,
   input  wire logic                         panel_load_exec,
   // Panel load request to core
   output logic                              panel_load,
   output logic [hiobj_pkg::PANEL_W-1:0]     panel_num,
   // Handler outputs, active low
   output logic                              bin_nine_out,
   output logic                              out_of_bins_n,
   output logic                              err_out_n,
   output logic                              meas_complete_n,
   output logic                              conv_complete_n
);
   localparam int unsigned PW = hiobj_pkg::PANEL_W;

   // Three-stage sync; first stage only feeds the second
   logic [PW:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_st_q;
   logic [PW:0] pin_raw;
   assign pin_raw = {panel_load_exec, panel_sel_b6, panel_sel_b5, panel_sel_b4,
                     panel_sel_b3, panel_sel_b2, panel_sel_b1, panel_sel_b0};

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         pin_s1_q <= '1;
         pin_s2_q <= '1;
         pin_s3_q <= '1;
      end else begin
         pin_s1_q <= pin_raw;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   // Accept a bit only once stages two and three agree
   always_ff @(posedge clk_sys) begin
      if (srst) pin_st_q <= '1;
      else begin
         for (int i = 0; i <= PW; i++) begin
            if (pin_s2_q[i] == pin_s3_q[i]) pin_st_q[i] <= pin_s3_q[i];
         end
      end
   end

   // Level execute: load on its assertion, low pins mean ones
   logic exec_prev_q;
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         exec_prev_q <= 1'b0;
         panel_load  <= 1'b0;
         panel_num   <= hiobj_pkg::PANEL_RST;
      end else begin
         exec_prev_q <= ~pin_st_q[PW];
         panel_load  <= ~pin_st_q[PW] & ~exec_prev_q;
         if (~pin_st_q[PW] & ~exec_prev_q) panel_num <= ~pin_st_q[PW-1:0];
      end
   end

   // Measurement sequence
   hiobj_pkg::hiobj_state_e st_q;
   always_ff @(posedge clk_sys) begin
      if (srst) st_q <= hiobj_pkg::HIOBJ_IDLE;
      else begin
         unique case (st_q)
            hiobj_pkg::HIOBJ_IDLE: if (meas_start) st_q <= hiobj_pkg::HIOBJ_CONV;
            hiobj_pkg::HIOBJ_CONV: if (conv_done) st_q <= hiobj_pkg::HIOBJ_HOLD;
            hiobj_pkg::HIOBJ_HOLD: if (judge_valid) st_q <= hiobj_pkg::HIOBJ_DONE;
            hiobj_pkg::HIOBJ_DONE: if (meas_start) st_q <= hiobj_pkg::HIOBJ_CONV;
         endcase
      end
   end

   // Judgments latched before the end strobe falls
   logic judge_upd;
   logic gap_cnt_nz;
   logic [3:0] gap_q;
   assign judge_upd = (st_q == hiobj_pkg::HIOBJ_HOLD) && judge_valid;
   assign gap_cnt_nz = (gap_q != 4'h0);

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         bin_nine_out  <= 1'b1;
         out_of_bins_n <= 1'b1;
      end else if (judge_upd) begin
         bin_nine_out  <= ~(judge_bin == hiobj_pkg::BIN_NINE);
         out_of_bins_n <= ~((judge_bin == hiobj_pkg::BIN_NONE) ||
                            (judge_bin > hiobj_pkg::BIN_MAX));
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) err_out_n <= 1'b1;
      else if (meas_start) err_out_n <= ~err_event;
      else if (err_event) err_out_n <= 1'b0;
   end

   // Gap so outputs settle before the end strobe
   always_ff @(posedge clk_sys) begin
      if (srst) gap_q <= 4'h0;
      else if (judge_upd) gap_q <= 4'(hiobj_pkg::MEAS_GAP_CYC);
      else if (gap_cnt_nz) gap_q <= gap_q - 4'h1;
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         conv_complete_n <= 1'b1;
         meas_complete_n <= 1'b1;
      end else if (meas_start) begin
         conv_complete_n <= 1'b1;
         meas_complete_n <= 1'b1;
      end else begin
         if (st_q == hiobj_pkg::HIOBJ_CONV && conv_done) conv_complete_n <= 1'b0;
         if (st_q == hiobj_pkg::HIOBJ_DONE && gap_q == 4'h1) meas_complete_n <= 1'b0;
      end
   end

   // Strobe order and settling of the judgments
   a_meas_after_conv: assert property (
      @(posedge clk_sys) disable iff (srst)
         $fell(meas_complete_n) |-> !conv_complete_n)
      else $error("End strobe before conversion strobe");

   a_meas_judge_gap: assert property (
      @(posedge clk_sys) disable iff (srst)
         $fell(meas_complete_n) |-> $stable(bin_nine_out) && $stable(out_of_bins_n))
      else $error("Judgment moved at end strobe");

   // End strobe must not fall within the settling gap
   a_meas_not_early: assert property (
      @(posedge clk_sys) disable iff (srst)
         judge_upd |=> meas_complete_n ##1 meas_complete_n)
      else $error("End strobe inside settling gap");

   a_meas_gap_end: assert property (
      @(posedge clk_sys) disable iff (srst)
         (judge_upd && !meas_start) ##1 !meas_start [*2] |=> !meas_complete_n)
      else $error("End strobe missing after gap");

   a_meas_hold: assert property (
      @(posedge clk_sys) disable iff (srst)
         !meas_complete_n && !meas_start |=> !meas_complete_n)
      else $error("End strobe released early");

   a_bin_nine_map: assert property (
      @(posedge clk_sys) disable iff (srst)
         judge_upd |=> bin_nine_out == ($past(judge_bin) != hiobj_pkg::BIN_NINE))
      else $error("Bin nine wrong");

   // Judgments only move on a taken result
   a_bin_hold: assert property (
      @(posedge clk_sys) disable iff (srst)
         !judge_upd |=> $stable(bin_nine_out) && $stable(out_of_bins_n))
      else $error("Judgment moved without result");

   a_nine_not_oob: assert property (
      @(posedge clk_sys) disable iff (srst)
         !bin_nine_out |-> out_of_bins_n)
      else $error("Bin nine and out of bins together");

   a_oob_map: assert property (
      @(posedge clk_sys) disable iff (srst)
         judge_upd && judge_bin == hiobj_pkg::BIN_NONE |=> !out_of_bins_n)
      else $error("Out of bins missed");

   a_oob_high: assert property (
      @(posedge clk_sys) disable iff (srst)
         judge_upd && judge_bin > hiobj_pkg::BIN_MAX |=> !out_of_bins_n)
      else $error("Out of bins missed above range");

   a_oob_in: assert property (
      @(posedge clk_sys) disable iff (srst)
         judge_upd && judge_bin != hiobj_pkg::BIN_NONE && judge_bin <= hiobj_pkg::BIN_MAX |=> out_of_bins_n)
      else $error("Out of bins on a defined bin");

   a_conv_fall: assert property (
      @(posedge clk_sys) disable iff (srst)
         st_q == hiobj_pkg::HIOBJ_CONV && conv_done && !meas_start |=> !conv_complete_n)
      else $error("Conversion strobe late");

   a_conv_hold: assert property (
      @(posedge clk_sys) disable iff (srst)
         !conv_complete_n && !meas_start |=> !conv_complete_n)
      else $error("Conversion strobe released early");

   a_release_start: assert property (
      @(posedge clk_sys) disable iff (srst)
         meas_start |=> conv_complete_n && meas_complete_n)
      else $error("Strobes not released");

   a_err_level: assert property (
      @(posedge clk_sys) disable iff (srst)
         err_event |=> !err_out_n)
      else $error("Error not shown");

   a_err_hold: assert property (
      @(posedge clk_sys) disable iff (srst)
         !err_out_n && !meas_start |=> !err_out_n)
      else $error("Error dropped within measurement");

   a_err_clear: assert property (
      @(posedge clk_sys) disable iff (srst)
         meas_start && !err_event |=> err_out_n)
      else $error("Error not cleared at start");

   // Panel number only moves with a load pulse
   a_load_pulse: assert property (
      @(posedge clk_sys) disable iff (srst)
         panel_load |=> !panel_load)
      else $error("Load pulse too long");

   a_panel_changed: assert property (
      @(posedge clk_sys) disable iff (srst)
         $changed(panel_num) |-> $rose(panel_load))
      else $error("Panel number moved without load");
endmodule : hiobj_top
`default_nettype wire

// >>> testbench/hiobj_handler.sv
// Handler model driving panel-select and execute pins
`timescale 1ns/10ps
`default_nettype none
module hiobj_handler (
   // Clock and request
   input  wire logic       clk_sys,
   input  wire logic [6:0] num,
   input  wire logic       go,
   // Pins, active low
   output logic [6:0]      sel_n,
   output logic            exec_n
);
   initial begin
      sel_n = 7'h7f;
      exec_n = 1'b1;
      forever begin
         @(posedge clk_sys iff go);
         @(negedge clk_sys);
         sel_n = ~num;
         repeat (2) @(negedge clk_sys);
         exec_n = 1'b0;
         repeat (8) @(negedge clk_sys);
         exec_n = 1'b1;
      end
   end
endmodule : hiobj_handler
`default_nettype wire

// >>> testbench/tb_handler_io_bin_judgment.sv
// Testbench for the handler I/O bin judgment block
`timescale 1ns/10ps
`default_nettype none
module tb_handler_io_bin_judgment;
   logic       clk_sys, srst, meas_start, conv_done, judge_valid, err_event, go, exec_n, pload;
   logic       b9, oob_n, err_n, mc_n, idx_n;
   logic [3:0] judge_bin;
   logic [6:0] num, sel_n, pnum;
   int         n_errors, check_count, cyc, k, p;
   logic [3:0] tbl [5] = '{4'h0, 4'h9, 4'ha, 4'hb, 4'hf};
   hiobj_handler hnd_u (.clk_sys(clk_sys), .num(num), .go(go), .sel_n(sel_n), .exec_n(exec_n));
   hiobj_top dut_u (.clk_sys(clk_sys), .srst(srst), .meas_start(meas_start), .conv_done(conv_done),
      .judge_valid(judge_valid), .judge_bin(judge_bin), .err_event(err_event), .panel_sel_b0(sel_n[0]),
      .panel_sel_b1(sel_n[1]), .panel_sel_b2(sel_n[2]), .panel_sel_b3(sel_n[3]), .panel_sel_b4(sel_n[4]),
      .panel_sel_b5(sel_n[5]), .panel_sel_b6(sel_n[6]), .panel_load_exec(exec_n), .panel_load(pload),
      .panel_num(pnum), .bin_nine_out(b9), .out_of_bins_n(oob_n), .err_out_n(err_n),
      .meas_complete_n(mc_n), .conv_complete_n(idx_n));
   function automatic logic exp_oob_n(input logic [3:0] bin);
      return !(bin == 4'h0 || bin > 4'ha);
   endfunction : exp_oob_n
   task automatic chk(input string nm, input logic [6:0] exp, input logic [6:0] got);
      check_count++;
      if (exp !== got) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic chk1(input string nm, input logic exp, input logic got);
      chk(nm, {6'h00, exp}, {6'h00, got});
   endtask : chk1
   task automatic print_verdict();
      $display("Checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : print_verdict
   task automatic measure(input logic [3:0] bin, input logic err);
      int w;
      meas_start = 1'b1;
      @(negedge clk_sys);
      meas_start = 1'b0;
      repeat (2) @(negedge clk_sys);
      chk1("released", 1'b1, idx_n & mc_n);
      conv_done = 1'b1;
      err_event = err;
      @(negedge clk_sys);
      {conv_done, err_event} = 2'b00;
      chk1("conv_cmp", 1'b0, idx_n);
      judge_valid = 1'b1;
      judge_bin = bin;
      @(negedge clk_sys);
      judge_valid = 1'b0;
      judge_bin = 4'($urandom);
      chk1("bin_nine", bin != hiobj_pkg::BIN_NINE, b9);
      chk1("oob", exp_oob_n(bin), oob_n);
      chk1("meas_early", 1'b1, mc_n);
      chk1("err", !err, err_n);
      w = 0;
      while (mc_n !== 1'b0 && w < 8) begin
         @(negedge clk_sys);
         w++;
      end
      chk("meas_gap", 7'(hiobj_pkg::MEAS_GAP_CYC), 7'(w));
      chk1("meas_cmp", 1'b0, mc_n);
      chk1("conv_hold", 1'b0, idx_n);
      chk1("bin_hold", bin != hiobj_pkg::BIN_NINE, b9);
   endtask : measure
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // Ceiling well above the roughly 430 cycles the tests need
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         print_verdict();
      end
   end
   initial begin
      {srst, meas_start, conv_done, judge_valid, err_event, go} = 6'h20;
      judge_bin = 4'h0;
      num = 7'h00;
      k = $urandom(32'hc8e6);
      repeat (6) @(negedge clk_sys);
      srst = 1'b0;
      @(negedge clk_sys);
      chk("reset_out", 7'h1f, {2'b00, b9, oob_n, err_n, mc_n, idx_n});
      chk("reset_load", 7'h00, pnum | {6'h00, pload});
      for (k = 0; k < 24; k++) measure(k < 5 ? tbl[k] : 4'($urandom), $urandom_range(0, 3) == 0);
      $display("Measurement test done");
      for (k = 0; k < 8; k++) begin
         num = k == 0 ? 7'h00 : k == 1 ? 7'h7f : 7'($urandom);
         go = 1'b1;
         @(negedge clk_sys);
         go = 1'b0;
         p = 0;
         repeat (30) begin
            @(negedge clk_sys);
            if (pload === 1'b1) p++;
         end
         chk("loads", 7'h01, 7'(p));
         chk("panel_num", num, pnum);
      end
      $display("Panel load test done");
      srst = 1'b1;
      repeat (2) @(negedge clk_sys);
      srst = 1'b0;
      @(negedge clk_sys);
      chk("rerun_out", 7'h1f, {2'b00, b9, oob_n, err_n, mc_n, idx_n});
      chk("rerun_load", 7'h00, pnum | {6'h00, pload});
      measure(hiobj_pkg::BIN_NINE, 1'b1);
      $display("Mid-run reset test done");
      print_verdict();
   end
endmodule : tb_handler_io_bin_judgment
`default_nettype wire
